// >>> upconverter_aux_ram_amp_regs.sv
// Purpose: dac scale, auto update period, ram segment and amplitude scale registers
// Assumes: serial port engine on mclk_in delivers whole register words by index
// Notes:   control word bits arrive as plain inputs; pins are synchronised here
//
// How it works
// - 8-bit full-scale code at 0x03, resets 0xFF
// - update period at 0x04 acts immediately
// - period drives auto updates when enabled
// - segment zero used on trigger rising edge
// - segment one used on trigger falling edge
// - step rate lives in bits 47:32
// - end address lives in bits 31:22
// - start address lives in bits 15:6
// - playback mode lives in bits 2:0
// - amplitude register acts only when enabled
// - ramp rate paces automatic keying steps
// - no keying: field is scale directly
// - manual keying: field applied while pin high
// - automatic keying: field caps ramped scale
// - step size used only by automatic keying
`include "upconv_regs_defines.svh"
module upconverter_aux_ram_amp_regs
	import upconv_regs_pkg::*;
(
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [4:0] addr_in,
	input wire logic [63:0] wr_data_in,
	input wire logic ram_enable_in,
	input wire logic amp_enable_in,
	input wire logic auto_keying_in,
	input wire logic manual_keying_in,
	input wire logic auto_update_enable_in,
	input wire logic ram_trigger_pin_in,
	input wire logic amplitude_keying_in,
	output logic [63:0] rd_data_out,
	output logic rd_valid_out,
	output logic [7:0] dac_full_scale_code_out,
	output logic auto_update_pulse_out,
	output logic seg_valid_out,
	output logic seg_index_out,
	output logic [15:0] seg_step_rate_out,
	output logic [9:0] seg_end_addr_out,
	output logic [9:0] seg_start_addr_out,
	output logic [2:0] seg_mode_out,
	output logic amp_active_out,
	output logic [13:0] amplitude_scale_value_out
);

	// ----------------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------------
	logic [7:0] fsc_ff; // full-scale code
	logic [31:0] period_ff; // auto update period
	logic [15:0] seg_rate_ff [2]; // per-segment step rate
	logic [9:0] seg_end_ff [2]; // per-segment end address
	logic [9:0] seg_start_ff [2]; // per-segment start address
	logic [2:0] seg_mode_ff [2]; // per-segment playback mode
	logic [15:0] amp_rate_ff; // amplitude ramp rate
	logic [13:0] amp_scale_ff; // amplitude field / ceiling
	logic [1:0] amp_step_ff; // amplitude step size code
	logic [63:0] rd_data_ff;
	logic rd_valid_ff;
	logic [31:0] upd_cnt_ff; // auto update cycle counter
	logic upd_pulse_ff;
	logic [1:0] trig_sync_ff; // trigger pin synchroniser
	logic trig_prev_ff; // last synchronised trigger level
	logic [1:0] key_sync_ff; // keying pin synchroniser
	seg_sel_t seg_sel_ff;
	logic [15:0] seg_rate_out_ff;
	logic [9:0] seg_end_out_ff;
	logic [9:0] seg_start_out_ff;
	logic [2:0] seg_mode_out_ff;
	logic [15:0] ramp_cnt_ff; // ramp pacing counter
	ramp_state_t ramp_state_ff;
	logic [13:0] ramp_val_ff; // ramped amplitude
	logic [13:0] amp_out_ff;
	logic amp_active_ff;
	logic wr_fsc, wr_period, wr_amp;
	logic [1:0] wr_seg;
	logic trig_lvl, key_lvl;
	logic ramp_tick;
	logic [13:0] step_amt;
	logic [14:0] up_sum;
	logic [13:0] nxt_ramp;
	logic [13:0] nxt_amp;
	// write strobes per register
	assign wr_fsc = wr_en_in && (addr_in == `ADDR_DAC_FULL_SCALE_CTRL);
	assign wr_period = wr_en_in && (addr_in == `ADDR_AUTO_UPDATE_PERIOD);
	assign wr_seg[0] = wr_en_in && (addr_in == `ADDR_RAM_SEGMENT_ZERO);
	assign wr_seg[1] = wr_en_in && (addr_in == `ADDR_RAM_SEGMENT_ONE);
	assign wr_amp = wr_en_in && (addr_in == `ADDR_AMPLITUDE_SCALE_CTRL);

	// ----------------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------------
	// full-scale code; open bits 31:8 are simply not stored
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fsc_ff <= `RST_DAC_FULL_SCALE_CODE;
		end else if (wr_fsc) begin
			fsc_ff <= wr_data_in[`FSC_MSB:`FSC_LSB];
		end
	end
	// update period, live on the write itself
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			period_ff <= `RST_AUTO_UPDATE_PERIOD;
		end else if (wr_period) begin
			period_ff <= wr_data_in[31:0];
		end
	end
	// segment descriptors; open bits 21:16 and 5:3 dropped
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 2; i++) begin
				seg_rate_ff[i] <= `RST_SEG_RATE;
				seg_end_ff[i] <= `RST_SEG_ADDR;
				seg_start_ff[i] <= `RST_SEG_ADDR;
				seg_mode_ff[i] <= `RST_SEG_MODE;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_seg[i]) begin
					seg_rate_ff[i] <= wr_data_in[`SEG_RATE_MSB:`SEG_RATE_LSB];
					seg_end_ff[i] <= wr_data_in[`SEG_END_MSB:`SEG_END_LSB];
					seg_start_ff[i] <= wr_data_in[`SEG_START_MSB:`SEG_START_LSB];
					seg_mode_ff[i] <= wr_data_in[`SEG_MODE_MSB:`SEG_MODE_LSB];
				end
			end
		end
	end
	// amplitude register fields
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			amp_rate_ff <= `RST_AMP_RATE;
			amp_scale_ff <= `RST_AMP_SCALE;
			amp_step_ff <= `RST_AMP_STEP;
		end else if (wr_amp) begin
			amp_rate_ff <= wr_data_in[`AMP_RATE_MSB:`AMP_RATE_LSB];
			amp_scale_ff <= wr_data_in[`AMP_SCALE_MSB:`AMP_SCALE_LSB];
			amp_step_ff <= wr_data_in[`AMP_STEP_MSB:`AMP_STEP_LSB];
		end
	end

	// ----------------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------------
	// open bits and unmapped addresses read zero
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_data_ff <= 64'h0000_0000_0000_0000;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= rd_en_in;
			if (rd_en_in) begin
				case (addr_in)
					`ADDR_DAC_FULL_SCALE_CTRL: rd_data_ff <= {56'h0, fsc_ff};
					`ADDR_AUTO_UPDATE_PERIOD: rd_data_ff <= {32'h0, period_ff};
					`ADDR_RAM_SEGMENT_ZERO: rd_data_ff <= {16'h0, seg_rate_ff[0], seg_end_ff[0],
						6'h0, seg_start_ff[0], 3'h0, seg_mode_ff[0]};
					`ADDR_RAM_SEGMENT_ONE: rd_data_ff <= {16'h0, seg_rate_ff[1], seg_end_ff[1],
						6'h0, seg_start_ff[1], 3'h0, seg_mode_ff[1]};
					`ADDR_AMPLITUDE_SCALE_CTRL: rd_data_ff <= {32'h0, amp_rate_ff, amp_scale_ff,
						amp_step_ff};
					default: rd_data_ff <= 64'h0000_0000_0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------------
	// automatic update timer
	// ----------------------------------------------------------------------
	// pulses once every period+1 cycles; a period write restarts the count
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			upd_cnt_ff <= 32'h0000_0000;
			upd_pulse_ff <= 1'b0;
		end else if (!auto_update_enable_in || wr_period) begin
			upd_cnt_ff <= 32'h0000_0000;
			upd_pulse_ff <= 1'b0;
		end else if (upd_cnt_ff >= period_ff) begin
			upd_cnt_ff <= 32'h0000_0000;
			upd_pulse_ff <= 1'b1;
		end else begin
			upd_cnt_ff <= upd_cnt_ff + 32'h0000_0001;
			upd_pulse_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trig_sync_ff <= 2'b00;
			key_sync_ff <= 2'b00;
		end else begin
			trig_sync_ff <= {trig_sync_ff[0], ram_trigger_pin_in};
			key_sync_ff <= {key_sync_ff[0], amplitude_keying_in};
		end
	end
	assign trig_lvl = trig_sync_ff[1];
	assign key_lvl = key_sync_ff[1];

	// ----------------------------------------------------------------------
	// ram segment selection
	// ----------------------------------------------------------------------
	// trigger edge picks the segment; fields follow writes at once
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trig_prev_ff <= 1'b0;
			seg_sel_ff <= SEG_NONE;
		end else begin
			trig_prev_ff <= trig_lvl;
			if (!ram_enable_in) begin
				seg_sel_ff <= SEG_NONE;
			end else if (trig_lvl && !trig_prev_ff) begin
				seg_sel_ff <= SEG_ZERO;
			end else if (!trig_lvl && trig_prev_ff) begin
				seg_sel_ff <= SEG_ONE;
			end
		end
	end
	// selected descriptor onto the outputs, zero when none is active
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			seg_rate_out_ff <= `RST_SEG_RATE;
			seg_end_out_ff <= `RST_SEG_ADDR;
			seg_start_out_ff <= `RST_SEG_ADDR;
			seg_mode_out_ff <= `RST_SEG_MODE;
		end else if (seg_sel_ff == SEG_NONE) begin
			// nothing selected: present zeros
			seg_rate_out_ff <= `RST_SEG_RATE;
			seg_end_out_ff <= `RST_SEG_ADDR;
			seg_start_out_ff <= `RST_SEG_ADDR;
			seg_mode_out_ff <= `RST_SEG_MODE;
		end else begin
			// low bit of the selection indexes the descriptor
			seg_rate_out_ff <= seg_rate_ff[seg_sel_ff[0]];
			seg_end_out_ff <= seg_end_ff[seg_sel_ff[0]];
			seg_start_out_ff <= seg_start_ff[seg_sel_ff[0]];
			seg_mode_out_ff <= seg_mode_ff[seg_sel_ff[0]];
		end
	end

	// ----------------------------------------------------------------------
	// automatic keying ramp
	// ----------------------------------------------------------------------
	// one step every rate+1 cycles; step is 1, 2, 4 or 8
	assign ramp_tick = (ramp_cnt_ff >= amp_rate_ff);
	assign step_amt = 14'h0001 << amp_step_ff;
	assign up_sum = {1'b0, ramp_val_ff} + {1'b0, step_amt};
	// next ramp value, never above the ceiling and never below zero
	always_comb begin
		nxt_ramp = ramp_val_ff;
		if (ramp_val_ff > amp_scale_ff) begin
			nxt_ramp = amp_scale_ff;
		end else if (ramp_tick && ramp_state_ff == RAMP_UP) begin
			if (up_sum > {1'b0, amp_scale_ff}) begin
				nxt_ramp = amp_scale_ff;
			end else begin
				nxt_ramp = up_sum[13:0];
			end
		end else if (ramp_tick && ramp_state_ff == RAMP_DOWN) begin
			if (ramp_val_ff < step_amt) begin
				nxt_ramp = 14'h0000;
			end else begin
				nxt_ramp = ramp_val_ff - step_amt;
			end
		end
	end
	// ramp direction follows the keying pin
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ramp_state_ff <= RAMP_HOLD;
			ramp_cnt_ff <= 16'h0000;
			ramp_val_ff <= 14'h0000;
		end else if (!(amp_enable_in && auto_keying_in)) begin
			ramp_state_ff <= RAMP_HOLD;
			ramp_cnt_ff <= 16'h0000;
			ramp_val_ff <= 14'h0000;
		end else begin
			ramp_cnt_ff <= ramp_tick ? 16'h0000 : ramp_cnt_ff + 16'h0001;
			ramp_val_ff <= nxt_ramp;
			case (ramp_state_ff)
				RAMP_HOLD: ramp_state_ff <= key_lvl ? RAMP_UP : RAMP_DOWN;
				RAMP_UP: ramp_state_ff <= key_lvl ? RAMP_UP : RAMP_DOWN;
				RAMP_DOWN: ramp_state_ff <= key_lvl ? RAMP_UP : RAMP_DOWN;
				default: ramp_state_ff <= RAMP_HOLD;
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// amplitude scale output
	// ----------------------------------------------------------------------
	// unity when the register is out of the path
	always_comb begin
		if (!amp_enable_in) begin
			nxt_amp = `AMP_UNITY;
		end else if (auto_keying_in) begin
			nxt_amp = nxt_ramp;
		end else if (manual_keying_in) begin
			nxt_amp = key_lvl ? amp_scale_ff : 14'h0000;
		end else begin
			nxt_amp = amp_scale_ff;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			amp_out_ff <= `AMP_UNITY;
			amp_active_ff <= 1'b0;
		end else begin
			amp_out_ff <= nxt_amp;
			amp_active_ff <= amp_enable_in;
		end
	end

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	assign rd_data_out = rd_data_ff;
	assign rd_valid_out = rd_valid_ff;
	assign dac_full_scale_code_out = fsc_ff;
	assign auto_update_pulse_out = upd_pulse_ff;
	assign seg_valid_out = seg_sel_ff[1];
	assign seg_index_out = seg_sel_ff[0];
	assign seg_step_rate_out = seg_rate_out_ff;
	assign seg_end_addr_out = seg_end_out_ff;
	assign seg_start_addr_out = seg_start_out_ff;
	assign seg_mode_out = seg_mode_out_ff;
	assign amp_active_out = amp_active_ff;
	assign amplitude_scale_value_out = amp_out_ff;
endmodule

// >>> upconv_regs_defines.svh
// Purpose: offsets, field positions and reset values for the upconverter register bank
// Assumes: word index addressing as delivered by the serial port engine
// Notes:   definitions only
`ifndef UPCONV_REGS_DEFINES_SVH
`define UPCONV_REGS_DEFINES_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define ADDR_DAC_FULL_SCALE_CTRL 5'h03
`define ADDR_AUTO_UPDATE_PERIOD 5'h04
`define ADDR_RAM_SEGMENT_ZERO 5'h05
`define ADDR_RAM_SEGMENT_ONE 5'h06
`define ADDR_AMPLITUDE_SCALE_CTRL 5'h09

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FSC_MSB 7
`define FSC_LSB 0
`define SEG_RATE_MSB 47
`define SEG_RATE_LSB 32
`define SEG_END_MSB 31
`define SEG_END_LSB 22
`define SEG_START_MSB 15
`define SEG_START_LSB 6
`define SEG_MODE_MSB 2
`define SEG_MODE_LSB 0
`define AMP_RATE_MSB 31
`define AMP_RATE_LSB 16
`define AMP_SCALE_MSB 15
`define AMP_SCALE_LSB 2
`define AMP_STEP_MSB 1
`define AMP_STEP_LSB 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_DAC_FULL_SCALE_CODE 8'hFF
`define RST_AUTO_UPDATE_PERIOD 32'h0FFF_FFFF
`define RST_SEG_RATE 16'h0000
`define RST_SEG_ADDR 10'h000
`define RST_SEG_MODE 3'h0
`define RST_AMP_RATE 16'h0000
`define RST_AMP_SCALE 14'h0000
`define RST_AMP_STEP 2'h0
`define AMP_UNITY 14'h3FFF

`endif

// >>> upconv_regs_pkg.sv
// Purpose: types shared by the upconverter register bank
// Assumes: nothing
// Notes:   constants live in the defines header
package upconv_regs_pkg;

	// ----------------------------------------------------------------------
	// amplitude ramp direction
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		RAMP_HOLD = 2'b00,
		RAMP_UP = 2'b01,
		RAMP_DOWN = 2'b10
	} ramp_state_t;

	// active ram segment selection; bit 1 marks a selection, bit 0 names the segment
	typedef enum logic [1:0] {
		SEG_NONE = 2'b00,
		SEG_ZERO = 2'b10,
		SEG_ONE = 2'b11
	} seg_sel_t;

endpackage

// >>> upconv_aux_checker.sv
// Purpose: port checker for the dac scale, update period, ram segment and amplitude bank
// Assumes: word port, control levels and pins all seen on mclk_in
// Notes:   shadows only the period, its counter and the amplitude field
module upconv_aux_checker (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [4:0] addr_in,
	input wire logic [63:0] wr_data_in,
	input wire logic ram_enable_in,
	input wire logic amp_enable_in,
	input wire logic auto_keying_in,
	input wire logic manual_keying_in,
	input wire logic auto_update_enable_in,
	input wire logic ram_trigger_pin_in,
	input wire logic amplitude_keying_in,
	input wire logic [63:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic [7:0] dac_full_scale_code_out,
	input wire logic auto_update_pulse_out,
	input wire logic seg_valid_out,
	input wire logic seg_index_out,
	input wire logic [15:0] seg_step_rate_out,
	input wire logic [9:0] seg_end_addr_out,
	input wire logic [9:0] seg_start_addr_out,
	input wire logic [2:0] seg_mode_out,
	input wire logic amp_active_out,
	input wire logic [13:0] amplitude_scale_value_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] per_ff; // shadow of the update period
	logic [31:0] cnt_ff; // shadow of the update counter
	logic [13:0] fld_ff; // shadow of the amplitude field
	logic wr4; // period write this cycle
	logic hit; // counter reaches the period
	assign wr4 = wr_en_in && addr_in == 5'h04;
	assign hit = auto_update_enable_in && !wr4 && cnt_ff == per_ff;
	// shadow counter clears on a period write or while disabled
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			per_ff <= 32'h0FFF_FFFF;
			cnt_ff <= 32'h0000_0000;
		end else begin
			if (wr4) per_ff <= wr_data_in[31:0];
			if (wr4 || !auto_update_enable_in) cnt_ff <= 32'h0000_0000;
			else cnt_ff <= (cnt_ff == per_ff) ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
		end
	end
	// amplitude field shadow
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) fld_ff <= 14'h0000;
		else if (wr_en_in && addr_in == 5'h09) fld_ff <= wr_data_in[15:2];
	end
	// ----------------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	a_fsc_write: assert property (
		wr_en_in && addr_in == 5'h03 |=> dac_full_scale_code_out == $past(wr_data_in[7:0]))
		else $error("full-scale code not loaded");
	a_open_zero: assert property (
		rd_en_in && (addr_in == 5'h03 || addr_in == 5'h07) |=> rd_valid_out && rd_data_out[63:8] == 0)
		else $error("open bits read non-zero");
	a_period_pulse: assert property (
		1'b1 |-> auto_update_pulse_out == $past(hit))
		else $error("update pulse off period");
	a_seg_rise: assert property (
		$rose(ram_trigger_pin_in) ##0 (ram_enable_in && ram_trigger_pin_in) [*5]
		|-> seg_valid_out && !seg_index_out)
		else $error("segment zero not chosen");
	a_seg_fall: assert property (
		$fell(ram_trigger_pin_in) ##0 (ram_enable_in && !ram_trigger_pin_in) [*5]
		|-> seg_valid_out && seg_index_out)
		else $error("segment one not chosen");
	a_ram_off: assert property (
		!ram_enable_in [*2] |-> !seg_valid_out)
		else $error("segment active while ram off");
	a_amp_unity: assert property (
		!amp_enable_in |=> amplitude_scale_value_out == 14'h3FFF)
		else $error("scale not unity while disabled");
	a_amp_direct: assert property (
		amp_enable_in && !auto_keying_in && !manual_keying_in
		|=> amplitude_scale_value_out == $past(fld_ff))
		else $error("direct scale differs from field");
	a_manual_low: assert property (
		(amp_enable_in && !auto_keying_in && manual_keying_in && !amplitude_keying_in) [*5]
		|-> amplitude_scale_value_out == 14'h0000)
		else $error("manual keying low not zero");
	a_amp_ceiling: assert property (
		amp_enable_in && auto_keying_in |=> amplitude_scale_value_out <= $past(fld_ff))
		else $error("ramped scale above ceiling");
	cover property (seg_valid_out && seg_index_out);
	cover property (auto_update_pulse_out);
	cover property (auto_keying_in && fld_ff != 0 && amplitude_scale_value_out == fld_ff);
endmodule

bind upconverter_aux_ram_amp_regs upconv_aux_checker u_chk (.*);

// >>> upconv_host_model.sv
// Purpose: host side of the register word port
// Assumes: strobes sampled on the rising edge, driven on the falling edge
// Notes:   released data lines show the inverse of the last word
module upconv_host_model (
	input wire logic mclk_in,
	input wire logic rd_valid_in,
	input wire logic [63:0] rd_data_in,
	output logic wr_en_out,
	output logic rd_en_out,
	output logic [4:0] addr_out,
	output logic [63:0] wr_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = 5'h00;
		wr_data_out = 64'h0000_0000_0000_0000;
	end
	// one-cycle write strobe, then release
	task automatic wr(input logic [4:0] a, input logic [63:0] d);
		@(negedge mclk_in);
		wr_en_out = 1'b1;
		addr_out = a;
		wr_data_out = d;
		@(negedge mclk_in);
		wr_en_out = 1'b0;
		wr_data_out = ~d;
	endtask
	// one-cycle read strobe; word taken while valid stands
	task automatic rd(input logic [4:0] a, output logic [63:0] d);
		@(negedge mclk_in);
		rd_en_out = 1'b1;
		addr_out = a;
		@(negedge mclk_in);
		rd_en_out = 1'b0;
		d = rd_valid_in ? rd_data_in : ~rd_data_in;
	endtask
endmodule

// >>> upconverter_aux_ram_amp_regs_tb.sv
// Purpose: self-checking bench for the aux register bank
// Assumes: host model drives the word port, bench drives levels and pins
// Notes:   register image kept in a masked model array
module upconverter_aux_ram_amp_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in, nrst_in, wr_en, rd_en, rd_valid, ram_en, amp_en, auto_k, man_k, upd_en;
	logic pin_rt, pin_ak, pulse, seg_v, seg_i, amp_act;
	logic [4:0] addr;
	logic [63:0] wr_data, rd_data, d, s;
	logic [7:0] dac_full_scale_code;
	logic [15:0] rate;
	logic [9:0] ea, sa;
	logic [2:0] mode;
	logic [13:0] amp;
	logic [63:0] mdl [0:15]; // register image
	logic [4:0] al [0:5] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h07};
	int num_errors, n_checks, last, n;
	integer seed = 32'h2f59;
	upconv_host_model host (.mclk_in(mclk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
		.wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wr_data_out(wr_data));
	upconverter_aux_ram_amp_regs dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .wr_en_in(wr_en),
		.rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wr_data), .ram_enable_in(ram_en),
		.amp_enable_in(amp_en), .auto_keying_in(auto_k), .manual_keying_in(man_k),
		.auto_update_enable_in(upd_en), .ram_trigger_pin_in(pin_rt),
		.amplitude_keying_in(pin_ak), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
		.dac_full_scale_code_out(dac_full_scale_code), .auto_update_pulse_out(pulse), .seg_valid_out(seg_v),
		.seg_index_out(seg_i), .seg_step_rate_out(rate), .seg_end_addr_out(ea),
		.seg_start_addr_out(sa), .seg_mode_out(mode), .amp_active_out(amp_act),
		.amplitude_scale_value_out(amp));
	// writable bits of each register
	function automatic logic [63:0] mk(input logic [4:0] a);
		case (a)
			5'h03: mk = 64'h0000_0000_0000_00FF;
			5'h04, 5'h09: mk = 64'h0000_0000_FFFF_FFFF;
			5'h05, 5'h06: mk = 64'h0000_FFFF_FFC0_FFC7;
			default: mk = 64'h0000_0000_0000_0000;
		endcase
	endfunction
	// compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// 100 MHz clock
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// watchdog
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
	// ----------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------
	initial begin
		{nrst_in, ram_en, amp_en, auto_k, man_k, upd_en, pin_rt, pin_ak} = 8'h00;
		foreach (mdl[i]) mdl[i] = 64'h0000_0000_0000_0000;
		mdl[3] = 64'h0000_0000_0000_00FF;
		mdl[4] = 64'h0000_0000_0FFF_FFFF;
		repeat (2) @(negedge mclk_in);
		nrst_in = 1'b1;
		// reset values and unmapped read
		foreach (al[i]) begin
			host.rd(al[i], d);
			chk(d, mdl[al[i]]);
		end
		chk(dac_full_scale_code, 8'hFF);
		chk(amp, 14'h3FFF);
		// random words, open bits dropped, unmapped ignored
		repeat (4) foreach (al[i]) begin
			s = {$random(seed), $random(seed)};
			host.wr(al[i], s);
			mdl[al[i]] = s & mk(al[i]);
			host.rd(al[i], d);
			chk(d, mdl[al[i]]);
		end
		chk(dac_full_scale_code, mdl[3][7:0]);
		// segment selection on trigger edges
		ram_en = 1'b1;
		for (int i = 0; i < 2; i++) begin
			pin_rt = ~pin_rt;
			repeat (6) @(negedge mclk_in);
			s = mdl[5 + i];
			chk({seg_v, seg_i, rate, ea, sa, mode}, {1'b1, i[0], s[47:32], s[31:22], s[15:6], s[2:0]});
		end
		ram_en = 1'b0;
		pin_rt = 1'b1;
		repeat (6) @(negedge mclk_in);
		chk(seg_v, 1'b0);
		// update period 3 then 1, each written while the timer is disabled
		for (int p = 3; p > 0; p -= 2) begin
			host.wr(5'h04, 64'(p));
			upd_en = 1'b1;
			last = -1;
			n = 0;
			for (int c = 0; c < 40; c++) begin
				@(negedge mclk_in);
				if (pulse === 1'b1) begin
					if (last >= 0) chk(c - last, p + 1);
					last = c;
					n++;
				end
			end
			chk(n > 40 / (p + 1) - 2, 1);
			upd_en = 1'b0;
		end
		// amplitude: direct, manual keying, automatic ramp and ceiling
		amp_en = 1'b1;
		host.wr(5'h09, 64'h0000_0000_0000_0403);
		repeat (3) @(negedge mclk_in);
		chk({amp_act, amp}, {1'b1, 14'h0100});
		{man_k, pin_ak} = 2'b11;
		repeat (5) @(negedge mclk_in);
		chk(amp, 14'h0100);
		pin_ak = 1'b0;
		repeat (5) @(negedge mclk_in);
		chk(amp, 14'h0000);
		{man_k, auto_k, pin_ak} = 3'b011;
		repeat (60) @(negedge mclk_in);
		chk(amp, 14'h0100);
		host.wr(5'h09, 64'h0000_0000_FFFF_0102);
		repeat (3) @(negedge mclk_in);
		chk(amp, 14'h0040);
		host.wr(5'h09, 64'h0000_0000_0000_0100);
		pin_ak = 1'b0;
		repeat (80) @(negedge mclk_in);
		chk(amp, 14'h0000);
		// slow ramp: one unit step every fourth cycle, about ten in forty
		host.wr(5'h09, 64'h0000_0000_0003_0100);
		pin_ak = 1'b1;
		repeat (40) @(negedge mclk_in);
		chk(amp >= 14'h0007 && amp <= 14'h000B, 1);
		amp_en = 1'b0;
		repeat (2) @(negedge mclk_in);
		chk({amp_act, amp}, {1'b0, 14'h3FFF});
		test_done();
	end
endmodule
